// file: inc/plldh_pkg.sv
// package for the pll lock detect and holdover block
// assumes a single 20 MHz clock domain and a byte-wide register port
package plldh_pkg;
  // ==========================================================
  // register offsets
  localparam logic [9:0] ADDR_STATUS_PIN = 10'h017;
  localparam logic [9:0] ADDR_LOCK_WIN = 10'h018;
  localparam logic [9:0] ADDR_DIV_DELAY = 10'h019;
  localparam logic [9:0] ADDR_LOCK_SEL = 10'h01a;
  localparam logic [9:0] ADDR_WATCH_PIN = 10'h01b;
  localparam logic [9:0] ADDR_REF_CTRL = 10'h01c;
  localparam logic [9:0] ADDR_HOLD_CTRL = 10'h01d;
  localparam logic [9:0] ADDR_UPDATE = 10'h232;
  localparam logic [9:0] ADDR_LOCK_STAT = 10'h01f;
  localparam int NUM_CFG = 7;
  // ==========================================================
  // field positions
  localparam int LW_CNT_LO = 5;
  localparam int LW_RANGE_BIT = 4;
  localparam int LW_DIS_BIT = 3;
  localparam int HC_EN0_BIT = 0;
  localparam int HC_MAN_BIT = 1;
  localparam int HC_EN2_BIT = 2;
  localparam int HC_CMP_BIT = 3;
  localparam int SP_ABW_LO = 0;
  localparam int SP_SEL_LO = 2;
  localparam int DD_REF_LO = 0;
  localparam int DD_REF_EN = 3;
  localparam int DD_FB_LO = 4;
  localparam int DD_FB_EN = 7;
  localparam int RC_SEL_BIT = 0;
  // ==========================================================
  // values after reset and codes
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] UPDATE_GO = 8'h01;
  localparam logic [5:0] LSEL_DLD = 6'h00;
  localparam logic [5:0] LSEL_CHARGE = 6'h04;
  localparam logic [5:0] WSEL_CMP_HI = 6'h0a;
  localparam logic [5:0] WSEL_CMP_LO = 6'h0b;
  // charge emulation terminal count, in detector cycles
  localparam logic [7:0] CHARGE_TERM = 8'h20;
  // lock counts for codes 00..11
  localparam logic [7:0] LOCK_CNT0 = 8'h05;
  localparam logic [7:0] LOCK_CNT1 = 8'h10;
  localparam logic [7:0] LOCK_CNT2 = 8'h40;
  localparam logic [7:0] LOCK_CNT3 = 8'hff;
  // ==========================================================
  // holdover states
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_HOLD = 2'b01,
    HS_WAIT = 2'b11,
    HS_BLOCK = 2'b10
  } plldh_hold_t;
endpackage

// file: verilog/plldh_phase_win.sv
// phase window comparator with lock and unlock thresholds
// assumes the phase error magnitude is already measured in fine units
`timescale 1ns/1ps
`default_nettype none
module plldh_phase_win (
  input wire logic [7:0] err,
  input wire logic range_low,
  input wire logic [1:0] abw,
  output logic in_lock_win,
  output logic out_unlock_win
);
  logic [7:0] lock_thr;
  logic [7:0] unlock_thr;
  // ==========================================================
  // thresholds: range bit zero gives the wide window
  assign lock_thr = (range_low ? 8'h04 : 8'h10) + {6'h00, abw};
  assign unlock_thr = {lock_thr[6:0], 1'b0}; // twice as wide for hysteresis
  assign in_lock_win = err < lock_thr;
  assign out_unlock_win = err > unlock_thr;
endmodule
`default_nettype wire

// file: verilog/plldh_top.sv
// lock detect and holdover control for the pll
// assumes ref/fb edge pulses and phase error come from the detector on CLK
// Contract
// [R1] lock asserts after programmed consecutive in-window detector cycles
// [R2] lock holds until one cycle exceeds the wider unlock threshold
// [R3] window set by range bit, antibacklash field, lock count
// [R4] count code 00 means five consecutive cycles
// [R5] disable bit turns lock detection off unless zero
// [R6] reference and feedback divider delays, enable plus three-bit value
// [R7] six-bit select chooses lock pin source, 000100 is charge mode
// [R8] charge mode sources while locked, shorts pin when unlocked
// [R9] comparator output selectable, either polarity, on watch and status pins
// [R10] holdover works only with both enable bits set
// [R11] control bit zero selects automatic, one selects manual holdover
// [R12] manual holdover enters on align pin falling edge
// [R13] exit waits for next reference detector edge after pin high
// [R14] exit resets B counter, prescaler untouched
// [R15] host sets channel dividers to ignore align pin
// [R16] automatic holdover enters on low sensed lock pin
// [R17] comparator disabled means lock pin sensed high
// [R18] re-entry blocked until lock and pin charged again
// [R19] holdover follows selected reference, ends at next reference edge
// [R20] host calibrates vco before setting holdover enable
// [R21] writing 01 to update register applies pending settings
// [R22] host uses charge mode for automatic holdover
// [R23] charge modelled as counter of lock cycles, high at terminal
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module plldh_top
  import plldh_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [9:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic PFD_EVT,
  input wire logic [7:0] PFD_ERR,
  input wire logic REF_EDGE,
  input wire logic ALIGN_PIN_N,
  input wire logic LD_PIN_IN,
  output logic LD_PIN_OUT,
  output logic LD_PIN_OE,
  output logic LD_CHARGE,
  output logic WATCH_PIN,
  output logic STATUS_PIN,
  output logic REF_SELECT,
  output logic [2:0] REF_DELAY,
  output logic REF_DELAY_EN,
  output logic [2:0] FB_DELAY,
  output logic FB_DELAY_EN,
  output logic CP_HIZ,
  output logic B_CNT_RST
);
  import plldh_pkg::*;

  // ==========================================================
  // register file: shadow and active copies
  logic [7:0] shadow_q [NUM_CFG];
  logic [7:0] active_q [NUM_CFG];
  logic [9:0] addr_base;
  logic upd_go;
  logic [7:0] lw_a;
  logic [7:0] hc_a;
  logic [7:0] sp_a;
  logic [7:0] dd_a;
  logic [7:0] ls_a;
  logic [7:0] wp_a;
  logic [7:0] rc_a;

  function automatic logic cfg_hit(input logic [9:0] a, input int idx);
    cfg_hit = (a == ADDR_STATUS_PIN + 10'(idx));
  endfunction

  assign addr_base = ADDR_STATUS_PIN;
  assign upd_go = WR && (ADDR == ADDR_UPDATE) && (WDATA == UPDATE_GO); // [R21]

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CFG; gi++) begin : g_cfg
      // shadow written by host, copied to active on update
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          shadow_q[gi] <= CFG_RESET;
          active_q[gi] <= CFG_RESET;
        end else if (CE) begin
          if (WR && cfg_hit(ADDR, gi)) begin
            shadow_q[gi] <= WDATA;
          end
          if (upd_go) begin
            active_q[gi] <= shadow_q[gi]; // [R21]
          end
        end
      end
    end
  endgenerate

  assign sp_a = active_q[0];
  assign lw_a = active_q[1];
  assign dd_a = active_q[2];
  assign ls_a = active_q[3];
  assign wp_a = active_q[4];
  assign rc_a = active_q[5];
  assign hc_a = active_q[6];

  // ==========================================================
  // pin synchronisers for align and lock pin sense
  logic [1:0] align_sync_q;
  logic [1:0] ldin_sync_q;
  logic align_prev_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      align_sync_q <= 2'b11;
      ldin_sync_q <= 2'b00;
      align_prev_q <= 1'b1;
    end else if (CE) begin
      align_sync_q <= {align_sync_q[0], ALIGN_PIN_N};
      ldin_sync_q <= {ldin_sync_q[0], LD_PIN_IN};
      align_prev_q <= align_sync_q[1];
    end
  end

  logic align_fall;
  logic align_high;
  assign align_high = align_sync_q[1];
  assign align_fall = align_prev_q && !align_sync_q[1]; // [R12] edge, not level

  // ==========================================================
  // digital lock detector
  logic in_win;
  logic out_win;
  logic [7:0] lock_need;
  logic [7:0] lock_cnt_q;
  logic lock_q;
  logic det_en;

  plldh_phase_win u_win (
    .err(PFD_ERR),
    .range_low(lw_a[LW_RANGE_BIT]),
    .abw(sp_a[SP_ABW_LO +: 2]),
    .in_lock_win(in_win),
    .out_unlock_win(out_win)
  ); // [R3]

  assign det_en = !lw_a[LW_DIS_BIT]; // [R5]
  assign lock_need = (lw_a[LW_CNT_LO +: 2] == 2'b00) ? LOCK_CNT0 : // [R4]
                     (lw_a[LW_CNT_LO +: 2] == 2'b01) ? LOCK_CNT1 :
                     (lw_a[LW_CNT_LO +: 2] == 2'b10) ? LOCK_CNT2 : LOCK_CNT3; // [R1]

  // consecutive count while unlocked, single bad cycle drops lock
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      lock_q <= 1'b0;
      lock_cnt_q <= 8'h00;
    end else if (CE) begin
      if (!det_en) begin
        lock_q <= 1'b0; // [R5]
        lock_cnt_q <= 8'h00;
      end else if (PFD_EVT) begin
        if (lock_q) begin
          lock_q <= !out_win; // [R2]
          lock_cnt_q <= 8'h00;
        end else if (!in_win) begin
          lock_cnt_q <= 8'h00; // [R1]
        end else if (lock_cnt_q + 8'h01 >= lock_need) begin
          lock_q <= 1'b1; // [R1]
          lock_cnt_q <= 8'h00;
        end else begin
          lock_cnt_q <= lock_cnt_q + 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // charge-mode emulation of the lock pin capacitor
  logic [7:0] chg_cnt_q;
  logic charge_mode;
  assign charge_mode = (ls_a[5:0] == LSEL_CHARGE); // [R7]

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      chg_cnt_q <= 8'h00;
    end else if (CE) begin
      if (!lock_q) begin
        chg_cnt_q <= 8'h00; // [R8] instant discharge
      end else if (PFD_EVT && chg_cnt_q != CHARGE_TERM) begin
        chg_cnt_q <= chg_cnt_q + 8'h01; // [R23]
      end
    end
  end

  logic charged;
  assign charged = (chg_cnt_q == CHARGE_TERM); // [R23]
  // lock pin: source while locked in charge mode, drive the flag for the DLD select, else low
  assign LD_PIN_OE = 1'b1;
  assign LD_PIN_OUT = charge_mode ? lock_q : (ls_a[5:0] == LSEL_DLD) && lock_q; // [R8] [R7]
  assign LD_CHARGE = charge_mode && lock_q; // [R8]

  // internal comparator: emulated level in charge mode, else pin sense
  logic cmp_out;
  logic ld_sensed;
  assign cmp_out = charge_mode ? charged : ldin_sync_q[1];
  assign ld_sensed = hc_a[HC_CMP_BIT] ? cmp_out : 1'b1; // [R17]

  // ==========================================================
  // holdover state machine
  plldh_hold_t hs_q;
  plldh_hold_t hs_d;
  logic hold_en;
  logic manual;
  logic b_rst_d;
  assign hold_en = hc_a[HC_EN0_BIT] && hc_a[HC_EN2_BIT]; // [R10]
  assign manual = hc_a[HC_MAN_BIT]; // [R11]

  // next state; exit on the selected reference's edge, or from HS_HOLD at once when disabled
  always_comb begin
    hs_d = hs_q;
    b_rst_d = 1'b0;
    unique case (hs_q)
      HS_IDLE: begin
        if (hold_en && manual && align_fall) begin
          hs_d = HS_HOLD; // [R12]
        end else if (hold_en && !manual && !ld_sensed) begin
          hs_d = HS_HOLD; // [R16]
        end
      end
      HS_HOLD: begin
        if (!hold_en) begin
          hs_d = HS_IDLE; // [R10]
        end else if (manual ? align_high : 1'b1) begin
          hs_d = HS_WAIT;
        end
      end
      HS_WAIT: begin
        if (REF_EDGE) begin
          hs_d = manual ? HS_IDLE : HS_BLOCK; // [R13] [R19]
          b_rst_d = 1'b1; // [R14]
        end
      end
      HS_BLOCK: begin
        if (!hold_en || (lock_q && ld_sensed)) begin
          hs_d = HS_IDLE; // [R18]
        end
      end
    endcase
  end

  logic b_rst_q;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hs_q <= HS_IDLE;
      b_rst_q <= 1'b0;
    end else if (CE) begin
      hs_q <= hs_d;
      b_rst_q <= b_rst_d;
    end
  end

  assign CP_HIZ = (hs_q == HS_HOLD) || (hs_q == HS_WAIT); // [R12] [R13]
  assign B_CNT_RST = b_rst_q; // [R14]

  // ==========================================================
  // pin muxes for comparator output
  function automatic logic pin_sel(input logic [5:0] code, input logic c, input logic l);
    pin_sel = (code == WSEL_CMP_HI) ? c : (code == WSEL_CMP_LO) ? !c : (code == LSEL_DLD) ? l : 1'b0;
  endfunction

  logic watch_d;
  logic status_d;
  assign watch_d = pin_sel({1'b0, wp_a[4:0]}, cmp_out, lock_q); // [R9]
  assign status_d = pin_sel(sp_a[SP_SEL_LO +: 6], cmp_out, lock_q); // [R9]

  // registered data outputs
  logic [7:0] rd_data;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      WATCH_PIN <= 1'b0;
      STATUS_PIN <= 1'b0;
      RDATA <= 8'h00;
    end else if (CE) begin
      WATCH_PIN <= watch_d;
      STATUS_PIN <= status_d;
      RDATA <= rd_data;
    end
  end

  // divider delay cells and reference choice
  assign REF_DELAY = dd_a[DD_REF_LO +: 3]; // [R6]
  assign REF_DELAY_EN = dd_a[DD_REF_EN]; // [R6]
  assign FB_DELAY = dd_a[DD_FB_LO +: 3]; // [R6]
  assign FB_DELAY_EN = dd_a[DD_FB_EN]; // [R6]
  assign REF_SELECT = rc_a[RC_SEL_BIT]; // [R19]

  // ==========================================================
  // read mux: shadow values, plus a status word; unmapped reads zero
  logic [9:0] rd_off;
  assign rd_off = ADDR - addr_base;
  assign rd_data = !RD ? 8'h00 :
                   (ADDR == ADDR_LOCK_STAT) ? {3'b000, charged, hs_q, CP_HIZ, lock_q} :
                   (ADDR >= ADDR_STATUS_PIN && ADDR <= ADDR_HOLD_CTRL) ? shadow_q[rd_off[2:0]] :
                   8'h00;
endmodule
`default_nettype wire

// file: tb/plldh_far_model.sv
// far side model: detector pulses and the lock pin load
// assumes the bench calls its tasks from its main sequence
`timescale 1ns/1ps
`default_nettype none
module plldh_far_model (
  input wire logic CLK,
  input wire logic LD_PIN_OUT,
  input wire logic LD_PIN_OE,
  output logic PFD_EVT,
  output logic [7:0] PFD_ERR,
  output logic REF_EDGE,
  output logic LD_PIN_IN
);
  // ==========================================
  // pin level, pulled up when released
  assign LD_PIN_IN = LD_PIN_OE ? LD_PIN_OUT : 1'b1;
  initial begin
    PFD_EVT = 1'b0;
    PFD_ERR = 8'h00;
    REF_EDGE = 1'b0;
  end
  // one comparison; error is junk outside the pulse
  task automatic pfd(input logic [7:0] e);
    @(posedge CLK);
    PFD_EVT <= 1'b1;
    PFD_ERR <= e;
    @(posedge CLK);
    PFD_EVT <= 1'b0;
    PFD_ERR <= ~e;
    repeat (2) @(posedge CLK);
  endtask
  // reference edge at the detector
  task automatic ref_edge;
    @(posedge CLK);
    REF_EDGE <= 1'b1;
    @(posedge CLK);
    REF_EDGE <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/plldh_top_properties.sv
// checker for the lock detect and holdover block
// assumes it is bound to plldh_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module plldh_props
  import plldh_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [9:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic PFD_EVT,
  input wire logic REF_EDGE,
  input wire logic LD_PIN_OUT,
  input wire logic LD_PIN_OE,
  input wire logic LD_CHARGE,
  input wire logic REF_SELECT,
  input wire logic [2:0] REF_DELAY,
  input wire logic [2:0] FB_DELAY,
  input wire logic CP_HIZ,
  input wire logic B_CNT_RST
);
  // ==========================================
  // clocking and the update strobe
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire logic upd = WR && ADDR == ADDR_UPDATE && WDATA == UPDATE_GO;
  // lock changes need an event, or an update that moved the select
  sequence s_evt_cause;
    $past(PFD_EVT) || $past(PFD_EVT, 2) || $past(upd) || $past(upd, 2);
  endsequence
  sequence s_ref_cause;
    $past(REF_EDGE) || $past(REF_EDGE, 2);
  endsequence
  // ==========================================
  // assertions
  a_lock_rise: assert property ($rose(LD_PIN_OUT) |-> s_evt_cause)
    else $error("lock pin rose without detector event");
  a_charge_drop: assert property ($fell(LD_CHARGE) |-> s_evt_cause)
    else $error("charge source dropped without event");
  a_bcnt_pulse: assert property (B_CNT_RST |=> !B_CNT_RST)
    else $error("counter reset longer than one cycle");
  a_bcnt_ref: assert property (B_CNT_RST |-> s_ref_cause)
    else $error("counter reset without reference edge");
  a_bcnt_hiz: assert property (B_CNT_RST |-> ##[0:1] !CP_HIZ)
    else $error("counter reset while pump stays off");
  // a disabling update may also end holdover, two cycles after the write
  a_hiz_exit: assert property ($fell(CP_HIZ) && !$past(upd, 2) |-> s_ref_cause)
    else $error("pump left holdover without reference edge");
  a_delay_upd: assert property ($changed({REF_DELAY, FB_DELAY, REF_SELECT}) |-> $past(upd) || $past(upd, 2))
    else $error("active setting changed without update");
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside its cycle");
  a_oe_high: assert property (LD_CHARGE |-> LD_PIN_OE && LD_PIN_OUT)
    else $error("lock pin not driven while sourcing");
endmodule
bind plldh_top plldh_props u_props (
  .CLK(CLK),
  .RST_N(RST_N),
  .ADDR(ADDR),
  .WDATA(WDATA),
  .WR(WR),
  .RD(RD),
  .RDATA(RDATA),
  .PFD_EVT(PFD_EVT),
  .REF_EDGE(REF_EDGE),
  .LD_PIN_OUT(LD_PIN_OUT),
  .LD_PIN_OE(LD_PIN_OE),
  .LD_CHARGE(LD_CHARGE),
  .REF_SELECT(REF_SELECT),
  .REF_DELAY(REF_DELAY),
  .FB_DELAY(FB_DELAY),
  .CP_HIZ(CP_HIZ),
  .B_CNT_RST(B_CNT_RST)
);
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the lock detect and holdover block
// assumes plldh_top, the far model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import plldh_pkg::*;
  logic CLK, RST_N, CE, WR, RD, ALIGN_PIN_N, PFD_EVT, REF_EDGE, LD_PIN_IN;
  logic LD_PIN_OUT, LD_PIN_OE, LD_CHARGE, WATCH_PIN, STATUS_PIN, REF_SELECT;
  logic REF_DELAY_EN, FB_DELAY_EN, CP_HIZ, B_CNT_RST, rd_q;
  logic [9:0] ADDR;
  logic [7:0] WDATA, RDATA, PFD_ERR, thr;
  logic [2:0] REF_DELAY, FB_DELAY;
  logic [15:0] exp_q[$];
  logic [15:0] note;
  logic [7:0] lcnt[4] = '{LOCK_CNT0, LOCK_CNT1, LOCK_CNT2, LOCK_CNT3};
  logic [7:0] hv[4] = '{8'h03, 8'h07, 8'h05, 8'h0d};
  logic [7:0] he[4] = '{8'h00, 8'h01, 8'h00, 8'h01};
  logic [31:0] seed = 32'h59966d1c;
  int bad_count = 0;
  int total_checks = 0;
  int bcnt = 0;
  int b0;
  plldh_top dut (
    .CLK(CLK),
    .RST_N(RST_N),
    .CE(CE),
    .ADDR(ADDR),
    .WDATA(WDATA),
    .WR(WR),
    .RD(RD),
    .RDATA(RDATA),
    .PFD_EVT(PFD_EVT),
    .PFD_ERR(PFD_ERR),
    .REF_EDGE(REF_EDGE),
    .ALIGN_PIN_N(ALIGN_PIN_N),
    .LD_PIN_IN(LD_PIN_IN),
    .LD_PIN_OUT(LD_PIN_OUT),
    .LD_PIN_OE(LD_PIN_OE),
    .LD_CHARGE(LD_CHARGE),
    .WATCH_PIN(WATCH_PIN),
    .STATUS_PIN(STATUS_PIN),
    .REF_SELECT(REF_SELECT),
    .REF_DELAY(REF_DELAY),
    .REF_DELAY_EN(REF_DELAY_EN),
    .FB_DELAY(FB_DELAY),
    .FB_DELAY_EN(FB_DELAY_EN),
    .CP_HIZ(CP_HIZ),
    .B_CNT_RST(B_CNT_RST)
  );
  plldh_far_model far (
    .CLK(CLK),
    .LD_PIN_OUT(LD_PIN_OUT),
    .LD_PIN_OE(LD_PIN_OE),
    .PFD_EVT(PFD_EVT),
    .PFD_ERR(PFD_ERR),
    .REF_EDGE(REF_EDGE),
    .LD_PIN_IN(LD_PIN_IN)
  );
  // ==========================================
  // clock, helpers
  initial CLK = 1'b0;
  always #25 CLK = ~CLK;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #5;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  // read notes its masked expectation for the watcher
  task automatic rd(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    exp_q.push_back({m, e});
    @(posedge CLK);
    RD <= 1'b0;
  endtask
  task automatic upd;
    wr(ADDR_UPDATE, UPDATE_GO);
  endtask
  task automatic do_reset;
    @(posedge CLK);
    RST_N <= 1'b0;
    ALIGN_PIN_N <= 1'b1;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================
  // watchers: read data against oldest note, counter reset pulses
  always @(posedge CLK) rd_q <= RD;
  always @(negedge CLK) begin
    if (rd_q === 1'b1) begin
      note = exp_q.pop_front();
      chk(RDATA & note[15:8], note[7:0]);
    end
  end
  always @(posedge CLK) if (B_CNT_RST === 1'b1) bcnt++;
  // hang guard, far beyond the few thousand cycles needed
  initial begin
    #1000000;
    bad_count++;
    final_report;
  end
  // ==========================================
  // main sequence
  initial begin
    RST_N = 1'b0;
    CE = 1'b1;
    ADDR = 10'h000;
    WDATA = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
    ALIGN_PIN_N = 1'b1;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    // reset values, shadow read back, unmapped place
    for (int a = 0; a < NUM_CFG; a++) begin
      rd(ADDR_STATUS_PIN + 10'(a), 8'hff, CFG_RESET);
      seed = lfsr(seed);
      wr(ADDR_STATUS_PIN + 10'(a), seed[7:0]);
      rd(ADDR_STATUS_PIN + 10'(a), 8'hff, seed[7:0]);
    end
    wr(10'h100, 8'h5a);
    rd(10'h100, 8'hff, 8'h00);
    // pending settings wait for the update write
    do_reset;
    wr(ADDR_DIV_DELAY, seed[15:8]);
    wr(ADDR_REF_CTRL, 8'h01);
    cyc(2);
    chk({FB_DELAY_EN, FB_DELAY, REF_DELAY_EN, REF_DELAY}, 8'h00);
    upd;
    cyc(2);
    chk({FB_DELAY_EN, FB_DELAY, REF_DELAY_EN, REF_DELAY}, seed[15:8]);
    chk({7'h00, REF_SELECT}, 8'h01);
    // every count code, both ranges, hysteresis band edge
    for (int i = 0; i < 4; i++) begin
      thr = (i[0] ? 8'd4 : 8'd16) + 8'(i);
      do_reset;
      wr(ADDR_STATUS_PIN, {WSEL_CMP_LO, 2'(i)});
      wr(ADDR_LOCK_WIN, {1'b0, 2'(i), i[0], 4'h0});
      wr(ADDR_WATCH_PIN, {2'b00, WSEL_CMP_HI});
      upd;
      repeat (lcnt[i] - 1) begin
        seed = lfsr(seed);
        far.pfd(seed[7:0] % thr);
      end
      rd(ADDR_LOCK_STAT, 8'h01, 8'h00);
      cyc(4);
      chk({5'h00, WATCH_PIN, STATUS_PIN, LD_PIN_OUT}, 8'h02);
      far.pfd(thr - 8'd1);
      rd(ADDR_LOCK_STAT, 8'h01, 8'h01);
      cyc(4);
      chk({5'h00, WATCH_PIN, STATUS_PIN, LD_PIN_OUT}, 8'h05);
      far.pfd(thr * 2);
      rd(ADDR_LOCK_STAT, 8'h01, 8'h01);
      far.pfd(thr * 2 + 8'd1);
      rd(ADDR_LOCK_STAT, 8'h01, 8'h00);
    end
    // detector switched off never locks
    do_reset;
    wr(ADDR_LOCK_WIN, 8'h08);
    upd;
    repeat (6) far.pfd(8'h00);
    rd(ADDR_LOCK_STAT, 8'h01, 8'h00);
    // charge mode: source while locked, charged at terminal count
    do_reset;
    wr(ADDR_LOCK_SEL, {2'b00, LSEL_CHARGE});
    upd;
    repeat (5) far.pfd(8'h00);
    cyc(1);
    chk({7'h00, LD_CHARGE}, 8'h01);
    repeat (CHARGE_TERM - 4) far.pfd(8'h01);
    rd(ADDR_LOCK_STAT, 8'h10, 8'h00);
    repeat (8) far.pfd(8'h02);
    rd(ADDR_LOCK_STAT, 8'h10, 8'h10);
    far.pfd(8'hff);
    cyc(1);
    chk({7'h00, LD_CHARGE}, 8'h00);
    rd(ADDR_LOCK_STAT, 8'h11, 8'h00);
    // holdover: gated manual, manual, comparator off, automatic
    for (int i = 0; i < 4; i++) begin
      do_reset;
      wr(ADDR_LOCK_SEL, {2'b00, LSEL_CHARGE});
      wr(ADDR_HOLD_CTRL, hv[i]);
      upd;
      @(posedge CLK);
      // no channel dividers here, so the align pin only feeds holdover
      ALIGN_PIN_N <= ~hv[i][1];
      cyc(5);
      chk({7'h00, CP_HIZ}, he[i]);
      @(posedge CLK);
      ALIGN_PIN_N <= 1'b1;
      cyc(6);
      chk({7'h00, CP_HIZ}, he[i]);
      b0 = bcnt;
      far.ref_edge;
      cyc(4);
      chk(8'(bcnt - b0), he[i]);
      chk({7'h00, CP_HIZ}, 8'h00);
      cyc(6);
      chk({7'h00, CP_HIZ}, 8'h00);
    end
    final_report;
  end
endmodule
`default_nettype wire
